// ### rtl/spd_defs.vh
// register map, field positions and reset values of the post-divider bank
`ifndef SPD_DEFS_VH
`define SPD_DEFS_VH

`define SPD_ADDR_A0       8'h8c
`define SPD_ADDR_A1       8'h8d
`define SPD_ADDR_A2       8'h8e
`define SPD_ADDR_B0       8'h8f
`define SPD_ADDR_B1       8'h90
`define SPD_ADDR_B2       8'h91
`define SPD_ADDR_C0       8'h92
`define SPD_ADDR_C1       8'h93
`define SPD_ADDR_C2       8'h94

`define SPD_RST_A         24'h000002
`define SPD_RST_B         24'h000002
`define SPD_RST_C         24'h000032

`define SPD_AB_MASK       24'h7fffff
`define SPD_AB_TOP_MASK   8'h7f
`define SPD_SHAPE_MSB     23
`define SPD_SHAPE_LSB     20
`define SPD_SHAPE_FRAME   4'hf
`define SPD_TYPE_BIT      19
`define SPD_POLAR_BIT     18
`define SPD_SEL_MSB       17
`define SPD_SEL_LSB       16
`define SPD_PERIOD_MSB    15
`define SPD_PERIOD_LSB    0

`define SPD_SEL_A         2'h0
`define SPD_SEL_B         2'h1
`define SPD_SEL_D         2'h3

`define SPD_MIN_RATIO     24'h000002

`endif

// ### rtl/spd_post_div_bank.v
// post-divider bank of the second synthesizer: dividers a, b, c and the frame-pulse generator of c
`timescale 1ns/100ps
`include "spd_defs.vh"

module spd_post_div_bank (
	input  wire        clk,
	input  wire        rstn,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        related_clk_d,
	output wire        clk_out_a,
	output wire        clk_out_b,
	output reg         clk_out_c
);

	reg  [23:0] second_synth_divider_a;
	reg  [23:0] second_synth_divider_b;
	reg  [23:0] second_synth_divider_c_frame;

	wire [2:0]  div_q;
	wire [23:0] ratio   [0:2];

	reg  [15:0] frame_cnt;
	reg         frame_pulse;
	reg         rel_q;
	reg         rel_now;
	reg  [15:0] next_frame_cnt;
	reg         next_frame_pulse;
	reg         next_clk_out_c;

	wire        frame_mode;
	wire [15:0] frame_period;
	wire [15:0] frame_last;
	wire        frame_at_last;
	wire        rel_rise;
	wire        rel_fall;
	wire        frame_type_edge;
	wire        frame_inverted;
	wire [1:0]  frame_sel;

	localparam [1:0] lane_low  = 2'h0;
	localparam [1:0] lane_mid  = 2'h1;
	localparam [1:0] lane_high = 2'h2;

	// ratios below two cannot be made from this clock; they run as two
	function [23:0] clamp_ratio;
		input [23:0] value;
		begin
			if (value < `SPD_MIN_RATIO) begin
				clamp_ratio = `SPD_MIN_RATIO;
			end else begin
				clamp_ratio = value;
			end
		end
	endfunction

	function [7:0] pick_byte;
		input [23:0] value;
		input [1:0]  lane;
		begin
			case (lane)
				lane_low:  pick_byte = value[7:0];
				lane_mid:  pick_byte = value[15:8];
				lane_high: pick_byte = value[23:16];
				default: pick_byte = 8'h00;
			endcase
		end
	endfunction

	// register writes, low byte at the low address
	// bytes land one edge apart, so a three-byte update briefly runs a mixed ratio
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			second_synth_divider_a       <= `SPD_RST_A;
			second_synth_divider_b       <= `SPD_RST_B;
			second_synth_divider_c_frame <= `SPD_RST_C;
		end else if (reg_wr) begin
			case (reg_addr)
				`SPD_ADDR_A0: second_synth_divider_a[7:0]        <= reg_wdata;
				`SPD_ADDR_A1: second_synth_divider_a[15:8]       <= reg_wdata;
				// reserved top bit is not stored, so it always reads zero
				`SPD_ADDR_A2: second_synth_divider_a[23:16]      <= reg_wdata & `SPD_AB_TOP_MASK;
				`SPD_ADDR_B0: second_synth_divider_b[7:0]        <= reg_wdata;
				`SPD_ADDR_B1: second_synth_divider_b[15:8]       <= reg_wdata;
				`SPD_ADDR_B2: second_synth_divider_b[23:16]      <= reg_wdata & `SPD_AB_TOP_MASK;
				`SPD_ADDR_C0: second_synth_divider_c_frame[7:0]  <= reg_wdata;
				`SPD_ADDR_C1: second_synth_divider_c_frame[15:8] <= reg_wdata;
				`SPD_ADDR_C2: second_synth_divider_c_frame[23:16] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read data registered, valid one cycle after the address
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`SPD_ADDR_A0: reg_rdata <= pick_byte(second_synth_divider_a, lane_low);
				`SPD_ADDR_A1: reg_rdata <= pick_byte(second_synth_divider_a, lane_mid);
				`SPD_ADDR_A2: reg_rdata <= pick_byte(second_synth_divider_a, lane_high);
				`SPD_ADDR_B0: reg_rdata <= pick_byte(second_synth_divider_b, lane_low);
				`SPD_ADDR_B1: reg_rdata <= pick_byte(second_synth_divider_b, lane_mid);
				`SPD_ADDR_B2: reg_rdata <= pick_byte(second_synth_divider_b, lane_high);
				`SPD_ADDR_C0: reg_rdata <= pick_byte(second_synth_divider_c_frame, lane_low);
				`SPD_ADDR_C1: reg_rdata <= pick_byte(second_synth_divider_c_frame, lane_mid);
				`SPD_ADDR_C2: reg_rdata <= pick_byte(second_synth_divider_c_frame, lane_high);
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	assign ratio[0] = clamp_ratio(second_synth_divider_a & `SPD_AB_MASK);
	assign ratio[1] = clamp_ratio(second_synth_divider_b & `SPD_AB_MASK);
	// ratio of c includes the shape bits; above 0xefffff is left to software
	assign ratio[2] = clamp_ratio(second_synth_divider_c_frame);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_div
			reg  [23:0] cnt;
			reg         q;
			wire [23:0] next_cnt;
			wire        next_q;
			// >= also catches a ratio lowered below the running count
			assign next_cnt = (cnt >= ratio[gi] - 24'h000001) ? 24'h000000 : cnt + 24'h000001;
			// high for floor(n/2): exact 50% even, one clock short odd
			assign next_q   = (next_cnt < (ratio[gi] >> 1));
			// c keeps counting in frame mode; its output is simply not used there
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cnt <= 24'h000000;
					q   <= 1'b0;
				end else begin
					cnt <= next_cnt;
					q   <= next_q;
				end
			end
			assign div_q[gi] = q;
		end
	endgenerate

	// c leaves through one more flop than a and b, so it lags them by a clock
	assign clk_out_a = div_q[0];
	assign clk_out_b = div_q[1];

	assign frame_mode   = (second_synth_divider_c_frame[`SPD_SHAPE_MSB:`SPD_SHAPE_LSB] == `SPD_SHAPE_FRAME);
	assign frame_period = second_synth_divider_c_frame[`SPD_PERIOD_MSB:`SPD_PERIOD_LSB];
	// a period of zero behaves as a period of one
	assign frame_last   = (frame_period == 16'h0000) ? 16'h0000 : frame_period - 16'h0001;
	assign frame_at_last = (frame_cnt >= frame_last);
	assign frame_sel       = second_synth_divider_c_frame[`SPD_SEL_MSB:`SPD_SEL_LSB];
	assign frame_type_edge = second_synth_divider_c_frame[`SPD_TYPE_BIT];
	assign frame_inverted  = second_synth_divider_c_frame[`SPD_POLAR_BIT];

	// related clock selection; the reserved code gives no edges, so no pulses
	// divider d runs on this same clock, so its level needs no synchroniser
	always @* begin
		case (frame_sel)
			`SPD_SEL_A: rel_now = div_q[0];
			`SPD_SEL_B: rel_now = div_q[1];
			`SPD_SEL_D: rel_now = related_clk_d;
			default:    rel_now = 1'b0;
		endcase
	end

	assign rel_rise = rel_now & ~rel_q;
	assign rel_fall = ~rel_now & rel_q;

	// frame counter and pulse shaping, ahead of the flops
	always @* begin
		next_frame_cnt   = frame_cnt;
		next_frame_pulse = frame_pulse;
		if (rel_rise) begin
			// frame boundary is the rising edge that wraps the count
			next_frame_cnt = frame_at_last ? 16'h0000 : frame_cnt + 16'h0001;
			if (frame_type_edge) begin
				next_frame_pulse = frame_at_last;
			end
		end else if (rel_fall && !frame_type_edge) begin
			// half a period either side of the boundary
			next_frame_pulse = frame_at_last;
		end
		if (frame_mode) begin
			next_clk_out_c = frame_pulse ^ frame_inverted;
		end else begin
			next_clk_out_c = div_q[2];
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rel_q       <= 1'b0;
			frame_cnt   <= 16'h0000;
			frame_pulse <= 1'b0;
			clk_out_c   <= 1'b0;
		end else begin
			rel_q       <= rel_now;
			frame_cnt   <= next_frame_cnt;
			frame_pulse <= next_frame_pulse;
			clk_out_c   <= next_clk_out_c;
		end
	end

endmodule

// ### test/spd_monitor.sv
// port checker of the post-divider bank
`timescale 1ns/100ps
module spd_monitor (
	input wire       clk,
	input wire       rstn,
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire       clk_out_a,
	input wire       clk_out_b,
	input wire       clk_out_c
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_A_RST: assert property ($rose(rstn) |=> !clk_out_a ##1 clk_out_a) else $error("a ratio");
	AST_B_RST: assert property ($rose(rstn) |=> !clk_out_b ##1 clk_out_b) else $error("b ratio");
	AST_C_RST: assert property ($rose(rstn) |-> ##2 clk_out_c [*8]) else $error("c ratio");
	AST_RD_A: assert property (reg_wr && reg_addr == 8'h8c ##1 !reg_wr && reg_addr == 8'h8c
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("a read");
	AST_RD_B: assert property (reg_wr && reg_addr == 8'h8f ##1 !reg_wr && reg_addr == 8'h8f
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("b read");
	AST_RD_C: assert property (reg_wr && reg_addr == 8'h92 ##1 !reg_wr && reg_addr == 8'h92
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("c read");
	AST_TOP: assert property (reg_addr == 8'h8e || reg_addr == 8'h91 |=> !reg_rdata[7]) else $error("bit 23");
	AST_UNMAP: assert property (reg_addr > 8'h94 |=> reg_rdata == 8'h00) else $error("unmapped");
endmodule
bind spd_post_div_bank spd_monitor mon (.clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
	.clk_out_a, .clk_out_b, .clk_out_c);

// ### test/tb_top.sv
// self-checking testbench of the post-divider bank
`timescale 1ns/100ps
`include "spd_defs.vh"
module tb_top;
	localparam [71:0] rv = {`SPD_RST_C, `SPD_RST_B, `SPD_RST_A};
	reg        clk = 0, rstn = 0, reg_wr = 0;
	reg  [7:0] reg_addr = 0, reg_wdata = 0;
	reg  [1:0] dc = 0;
	wire [7:0] reg_rdata;
	wire       clk_out_a, clk_out_b, clk_out_c;
	int        bad_count = 0, n_tests = 0;
	spd_post_div_bank uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .related_clk_d(dc[1]), .clk_out_a(clk_out_a), .clk_out_b(clk_out_b),
		.clk_out_c(clk_out_c));
	initial forever #50 clk = ~clk;
	// divider d stand-in: period 4, high 2
	always @(posedge clk) dc <= #1 dc + 2'h1;
	task step; @(posedge clk); #1; endtask
	task chk(input string n, input logic [23:0] s, input logic [23:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// top byte first; settle covers the longest frame
	task w24(input [7:0] a, input [23:0] v);
		reg_wr = 1;
		for (int i = 2; i >= 0; i--) begin
			reg_addr = a + 8'(i);
			reg_wdata = v[8*i+:8];
			step;
		end
		reg_wr = 0;
		repeat (40) step;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		reg_addr = a;
		step;
		step;
		chk("rdata", {16'h0, reg_rdata}, {16'h0, e});
	endtask
	function logic o(input int s);
		return s == 0 ? clk_out_a : s == 1 ? clk_out_b : clk_out_c;
	endfunction
	task automatic meas(input int s, input int hi, input int lo);
		int h = 0, l = 0;
		for (int k = 0; k < 300 && o(s) !== 1'b0; k++) step;
		for (int k = 0; k < 300 && o(s) !== 1'b1; k++) step;
		while (o(s) === 1'b1 && h < 300) begin step; h++; end
		while (o(s) === 1'b0 && l < 300) begin step; l++; end
		chk("high", 24'(h), 24'(hi));
		chk("low", 24'(l), 24'(lo));
	endtask
	task t_reset;
		for (int i = 0; i < 9; i++) rd(8'h8c + 8'(i), rv[8*i+:8]);
		rd(8'h95, 8'h00);
		meas(0, 1, 1);
		meas(2, 25, 25);
	endtask
	task t_normal;
		w24(8'h8c, 24'h000005);
		rd(8'h8e, 8'h00);
		meas(0, 2, 3);
		w24(8'h8f, 24'h000006);
		rd(8'h91, 8'h00);
		meas(1, 3, 3);
		w24(8'h92, 24'h000007);
		meas(2, 3, 4);
	endtask
	task t_frame;
		w24(8'h8c, 24'h000002);
		w24(8'h92, 24'hf80004);
		meas(2, 2, 6);
		w24(8'h92, 24'hfc0004);
		meas(2, 6, 2);
		w24(8'h92, 24'hfb0004);
		meas(2, 4, 12);
		w24(8'h92, 24'hf10002);
		meas(2, 6, 6);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		bad_count++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rstn = 1;
		t_reset;
		t_normal;
		t_frame;
		test_done;
	end
endmodule
